// ===== shared/dmd_pkg.sv
/*
  Shared constants, types and decode functions for the data-space address
  decoder: internal RAM, register space, bit mapping and external moves.
  Assumes a single core clock domain; nothing here holds state.
*/
`default_nettype none

package dmd_pkg;

  // Internal RAM and register space geometry
  localparam int unsigned RAM_BYTES = 256;
  localparam int unsigned SFR_BYTES = 128;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] P2_LATCH_ADDR = 8'ha0;

  // Values after reset, and the filler read at unbuilt register addresses
  localparam logic [7:0] RAM_RESET = 8'h00;
  localparam logic [7:0] SFR_RESET = 8'h00;
  localparam logic [7:0] P2_LATCH_RESET = 8'hff;
  localparam logic [7:0] UNIMPL_READ = 8'h00;

  // One bit per register address 80h..ffh, row f at the top
  localparam logic [127:0] SFR_IMPL_MASK = 128'h013d_013d_013d_013d_013d_013f_033f_3fbf;

  // Register addresses whose byte has unbuilt bit positions
  localparam logic [7:0] ADDR_INT_EN0 = 8'ha8;
  localparam logic [7:0] ADDR_INT_PRIO0 = 8'hb8;
  localparam logic [7:0] ADDR_INT_EN1 = 8'hc8;
  localparam logic [7:0] ADDR_STATUS = 8'hd0;
  localparam logic [7:0] ADDR_INT_PRIO1 = 8'hf8;
  localparam logic [7:0] MASK_INT_EN0 = 8'h9f;
  localparam logic [7:0] MASK_INT_PRIO0 = 8'h1f;
  localparam logic [7:0] MASK_INT_X1 = 8'h3f;
  localparam logic [7:0] MASK_STATUS = 8'hfd;
  localparam logic [7:0] MASK_FULL = 8'hff;

  // Addressing modes requested by the core, one-hot
  typedef enum logic [5:0] {
    MODE_DIRECT = 6'b000001,
    MODE_INDIRECT = 6'b000010,
    MODE_STACK = 6'b000100,
    MODE_BIT = 6'b001000,
    MODE_EXT_WIDE = 6'b010000,
    MODE_EXT_REG = 6'b100000
  } dmd_mode_t;

  // True where a register address has storage behind it
  function automatic logic sfr_implemented(input logic [7:0] addr);
    return SFR_IMPL_MASK[addr[6:0]];
  endfunction

  // Bits of a register that really hold state
  function automatic logic [7:0] sfr_bit_mask(input logic [7:0] addr);
    case (addr)
      ADDR_INT_EN0: return MASK_INT_EN0;
      ADDR_INT_PRIO0: return MASK_INT_PRIO0;
      ADDR_INT_EN1: return MASK_INT_X1;
      ADDR_INT_PRIO1: return MASK_INT_X1;
      ADDR_STATUS: return MASK_STATUS;
      default: return MASK_FULL;
    endcase
  endfunction

endpackage

`default_nettype wire

// ===== hdl/dmd_bit_locator.sv
/*
  Turns a bit address into the byte that holds it and the position inside it.
  Purely combinational; the caller supplies a stable bit address.
*/
`timescale 1ns/1ps
`default_nettype none

module dmd_bit_locator (
  input wire logic [7:0] bit_addr,
  output logic [7:0] byte_addr,
  output logic [2:0] bit_pos,
  output logic [7:0] bit_sel,
  output logic in_sfr
);
  import dmd_pkg::*;

  wire [7:0] ram_byte;
  wire [7:0] sfr_byte;

  // Low half lands in the 16 RAM bytes, high half in every eighth register
  assign in_sfr = bit_addr[7]; // see R13
  assign ram_byte = BIT_RAM_BASE + {4'h0, bit_addr[6:3]}; // see R12
  assign sfr_byte = {bit_addr[7:3], 3'b000}; // see R14
  assign byte_addr = in_sfr ? sfr_byte : ram_byte;
  assign bit_pos = bit_addr[2:0]; // Lowest bit address sits at the LSB
  assign bit_sel = 8'h01 << bit_pos;

endmodule

`default_nettype wire

// ===== hdl/dmd_data_space.sv
/*
  Data-space address decoder: 256-byte internal RAM, a separate register
  space, bit addressing and external data moves over the two address ports.
  Assumes the core holds a request until req_ready and that inputs are
  synchronous to clock.
*/
// Functional notes
// R1 - Internal RAM holds 256 bytes at addresses 00h to ffh.
// R2 - Lower 128 RAM bytes reachable both directly and indirectly.
// R3 - RAM at 80h and above only via indirect pointer or DMA.
// R4 - Direct addresses 80h to ffh select register space, not RAM.
// R5 - Stack pushes and pops address RAM indirectly through the stack pointer.
// R6 - Unimplemented register addresses give undefined data; nobody relies on it.
// R7 - Register storage and upper RAM are separate and hold independent values.
// R8 - Sixteen-bit pointer moves reach 64K; low byte port 0, high port 2.
// R9 - Pointer moves drive all sixteen lines; port 2 is not general I/O then.
// R10 - Register-pointer moves present only an 8-bit address, 256 bytes.
// R11 - Register-pointer moves leave port 2 on its latched value.
// R12 - Bit addresses 00h-7fh map to RAM bytes 20h-2fh, LSB lowest.
// R13 - Bit addresses 80h-ffh map to every eighth register, all eight bits.
// R14 - High bit address: register is address with low three bits cleared.
// R15 - Bit writes to unbuilt positions leave the register's other bits alone.
`timescale 1ns/1ps
`default_nettype none

module dmd_data_space (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire dmd_pkg::dmd_mode_t req_mode,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [15:0] req_wide_ptr,
  input wire logic [7:0] req_wdata,
  input wire logic req_wbit,
  input wire logic dma_valid,
  output logic dma_ready,
  input wire logic dma_write,
  input wire logic [7:0] dma_addr,
  input wire logic [7:0] dma_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_bit,
  output logic [7:0] port0_out,
  output logic port0_oe,
  output logic [7:0] port2_out,
  output logic port2_addr_mode,
  output logic ext_rd,
  output logic ext_wr,
  output logic [7:0] ext_wdata,
  input wire logic [7:0] ext_rdata
);
  import dmd_pkg::*;

  logic [7:0] ram_q [0:RAM_BYTES-1];
  logic [7:0] sfr_q [0:SFR_BYTES-1];
  logic ext_busy;
  logic ext_read;

  wire take_cpu;
  wire take_dma;
  wire is_direct;
  wire is_indirect;
  wire is_bit;
  wire is_xdptr;
  wire is_xreg;
  wire is_ext;
  wire [7:0] bit_byte;
  wire [2:0] bit_pos;
  wire [7:0] bit_sel;
  wire bit_in_sfr;
  wire cpu_ram;
  wire cpu_sfr;
  wire [7:0] ram_index;
  wire [6:0] sfr_index;
  wire [7:0] sfr_full_addr;
  wire [7:0] ram_at_index;
  wire [7:0] sfr_at_index;
  wire [7:0] sfr_mask;
  wire [7:0] sfr_read;
  wire [7:0] cur_byte;
  wire [7:0] bit_merged;
  wire [7:0] ram_new;
  wire [7:0] sfr_new;
  wire ram_we;
  wire sfr_we;
  wire [7:0] p2_latch;
  wire [7:0] next_port2;

  // Handshake: the core wins over DMA, nothing is taken while a move is out
  assign req_ready = !ext_busy;
  assign dma_ready = !ext_busy && !req_valid;
  assign take_cpu = req_valid && req_ready;
  assign take_dma = dma_valid && dma_ready;

  // Mode decode
  assign is_direct = (req_mode == MODE_DIRECT);
  assign is_indirect = (req_mode == MODE_INDIRECT) || (req_mode == MODE_STACK); // see R5
  assign is_bit = (req_mode == MODE_BIT);
  assign is_xdptr = (req_mode == MODE_EXT_WIDE);
  assign is_xreg = (req_mode == MODE_EXT_REG);
  assign is_ext = is_xdptr || is_xreg;

  dmd_bit_locator u_bit_locator (
    .bit_addr(req_addr),
    .byte_addr(bit_byte),
    .bit_pos(bit_pos),
    .bit_sel(bit_sel),
    .in_sfr(bit_in_sfr)
  );

  // Space select: a direct operand above 7fh never touches RAM
  assign cpu_sfr = (is_direct && req_addr[7]) || (is_bit && bit_in_sfr); // see R4
  assign cpu_ram = (is_direct && !req_addr[7]) || is_indirect || (is_bit && !bit_in_sfr); // see R2 R3
  assign ram_index = take_dma ? dma_addr : (is_bit ? bit_byte : req_addr); // see R1
  assign sfr_full_addr = is_bit ? bit_byte : req_addr;
  assign sfr_index = sfr_full_addr[6:0];

  // Read side; unbuilt register addresses read a fixed filler
  assign ram_at_index = ram_q[ram_index];
  assign sfr_at_index = sfr_q[sfr_index];
  assign sfr_read = sfr_implemented(sfr_full_addr) ? sfr_at_index : UNIMPL_READ; // see R6
  assign sfr_mask = sfr_implemented(sfr_full_addr) ? sfr_bit_mask(sfr_full_addr) : 8'h00;
  assign cur_byte = (cpu_sfr && !take_dma) ? sfr_read : ram_at_index; // Stale core mode must not steer DMA, see R3

  // Bit writes are a read-modify-write of the holding byte in one cycle
  assign bit_merged = req_wbit ? (cur_byte | bit_sel) : (cur_byte & ~bit_sel);
  assign ram_new = take_dma ? dma_wdata : (is_bit ? bit_merged : req_wdata);
  assign sfr_new = ((is_bit ? bit_merged : req_wdata) & sfr_mask) | (sfr_at_index & ~sfr_mask); // see R15
  assign ram_we = (take_cpu && req_write && cpu_ram) || (take_dma && dma_write);
  assign sfr_we = take_cpu && req_write && cpu_sfr; // see R7

  // RAM storage, written by core or DMA
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < RAM_BYTES; i++) begin
        ram_q[i] <= RAM_RESET;
      end
    end else if (ram_we) begin
      ram_q[ram_index] <= ram_new;
    end
  end

  // Register storage, its own array so shared addresses never alias RAM
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < SFR_BYTES; i++) begin
        sfr_q[i] <= (i == int'(P2_LATCH_ADDR[6:0])) ? P2_LATCH_RESET : SFR_RESET;
      end
    end else if (sfr_we) begin
      sfr_q[sfr_index] <= sfr_new; // see R7
    end
  end

  // Port 2 follows its latch except while the wide pointer owns it
  assign p2_latch = sfr_q[P2_LATCH_ADDR[6:0]];
  assign next_port2 = (take_cpu && is_xdptr) ? req_wide_ptr[15:8] : p2_latch; // see R9 R11

  // External move: address out for one cycle, data sampled at its end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ext_busy <= 1'b0;
      ext_read <= 1'b0;
      port0_out <= 8'h00;
      port0_oe <= 1'b0;
      port2_out <= P2_LATCH_RESET;
      port2_addr_mode <= 1'b0;
      ext_rd <= 1'b0;
      ext_wr <= 1'b0;
      ext_wdata <= 8'h00;
    end else begin
      ext_busy <= take_cpu && is_ext;
      ext_read <= take_cpu && is_ext && !req_write;
      port0_oe <= take_cpu && is_ext;
      port2_addr_mode <= take_cpu && is_xdptr; // see R9
      ext_rd <= take_cpu && is_ext && !req_write;
      ext_wr <= take_cpu && is_ext && req_write;
      port2_out <= next_port2;
      if (take_cpu && is_ext) begin
        port0_out <= is_xdptr ? req_wide_ptr[7:0] : req_addr; // see R8 R10
        ext_wdata <= req_wdata;
      end
    end
  end

  // Answers: internal reads after one cycle, external reads after two
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_bit <= 1'b0;
    end else begin
      rsp_valid <= ext_read || (take_cpu && !req_write && !is_ext) || (take_dma && !dma_write);
      if (ext_read) begin
        rsp_data <= ext_rdata;
      end else if (take_cpu || take_dma) begin
        rsp_data <= cur_byte;
      end
      if (take_cpu && is_bit) begin
        rsp_bit <= cur_byte[bit_pos]; // see R12 R13
      end
    end
  end

  // Checks: helper copies so sampled values are plain signals
  wire [7:0] wide_lo = req_wide_ptr[7:0];
  wire [7:0] wide_hi = req_wide_ptr[15:8];
  wire [7:0] ram_at_req = ram_q[req_addr];
  wire [7:0] ram_at_dma = ram_q[dma_addr];
  wire [7:0] ram_at_bit = ram_q[bit_byte];

  a_ram_read_data: assert property (@(posedge clock) disable iff (sys_rst) // see R1 R2
    take_cpu && !req_write && ((is_direct && !req_addr[7]) || is_indirect)
    |=> rsp_valid && rsp_data == $past(ram_at_req))
    else $error("RAM read answered with wrong data");

  a_direct_hi_sfr: assert property (@(posedge clock) disable iff (sys_rst) // see R3 R4 R7
    take_cpu && req_write && is_direct && req_addr[7]
    |=> ram_q[$past(req_addr)] == $past(ram_at_req))
    else $error("Direct high write disturbed RAM");

  a_indirect_upper_ram: assert property (@(posedge clock) disable iff (sys_rst) // see R3 R5
    take_cpu && req_write && is_indirect
    |=> ram_q[$past(req_addr)] == $past(req_wdata))
    else $error("Indirect or stack write missed RAM");

  a_wide_address: assert property (@(posedge clock) disable iff (sys_rst) // see R8 R9
    take_cpu && is_xdptr
    |=> port0_oe && port2_addr_mode && port0_out == $past(wide_lo) && port2_out == $past(wide_hi))
    else $error("Wide pointer address not on both ports");

  a_reg_ptr_p2: assert property (@(posedge clock) disable iff (sys_rst) // see R10 R11
    take_cpu && is_xreg
    |=> !port2_addr_mode && port2_out == $past(p2_latch) && port0_out == $past(req_addr))
    else $error("Register pointer move disturbed port 2");

  a_ext_read_seq: assert property (@(posedge clock) disable iff (sys_rst) // see R8
    take_cpu && is_ext && !req_write
    |=> ext_rd && !req_ready ##1 rsp_valid && !ext_rd)
    else $error("External read sequence wrong");

  a_bit_ram_map: assert property (@(posedge clock) disable iff (sys_rst) // see R12
    take_cpu && req_write && is_bit && !bit_in_sfr
    |=> ram_q[$past(bit_byte)] == ($past(req_wbit) ? ($past(ram_at_bit) | $past(bit_sel))
                                                   : ($past(ram_at_bit) & ~$past(bit_sel))))
    else $error("Bit write landed in wrong RAM bit");

  a_bit_sfr_keep: assert property (@(posedge clock) disable iff (sys_rst) // see R14 R15
    take_cpu && req_write && is_bit && bit_in_sfr
    |=> ((sfr_q[$past(sfr_index)] ^ $past(sfr_at_index)) & ~$past(bit_sel)) == 8'h00)
    else $error("Bit write altered other register bits");

  a_dma_priority: assert property (@(posedge clock) disable iff (sys_rst) // see R3
    req_valid || ext_busy |-> !dma_ready)
    else $error("DMA taken while core busy");

  a_dma_read_data: assert property (@(posedge clock) disable iff (sys_rst) // see R3
    take_dma && !dma_write
    |=> rsp_valid && rsp_data == $past(ram_at_dma))
    else $error("DMA read answered with wrong data");

  c_wide_read: cover property (@(posedge clock) disable iff (sys_rst)
    take_cpu && is_xdptr && !req_write ##2 rsp_valid);
  c_stack_upper: cover property (@(posedge clock) disable iff (sys_rst)
    take_cpu && req_mode == MODE_STACK && req_addr[7]);
  c_sfr_bit_write: cover property (@(posedge clock) disable iff (sys_rst)
    take_cpu && is_bit && bit_in_sfr && req_write);
  c_dma_upper: cover property (@(posedge clock) disable iff (sys_rst)
    take_dma && dma_write && dma_addr[7]);

endmodule

`default_nettype wire

// ===== testbench/dmd_ext_mem.sv
/*
  External data memory model on the far side of the external move port.
  Assumes one-cycle read and write strobes and separate address outputs.
*/
`timescale 1ns/1ps
`default_nettype none

module dmd_ext_mem (
  input wire logic clock,
  input wire logic [7:0] port0_out,
  input wire logic [7:0] port2_out,
  input wire logic ext_rd,
  input wire logic ext_wr,
  input wire logic [7:0] ext_wdata,
  output logic [7:0] ext_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  logic [15:0] addr;
  // Page byte always comes from port 2, so latch banking is seen too
  assign addr = {port2_out, port0_out};
  // Released bus shows the inverse of the last byte, never a stale match
  assign ext_rdata = ext_rd ? mem[addr] : ~last;
  // Memory starts cleared
  initial begin
    last = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  end
  // Store and read on the strobe cycle
  always @(posedge clock) begin
    if (ext_wr) begin
      mem[addr] <= ext_wdata;
    end
    if (ext_rd) begin
      last <= mem[addr];
    end
  end
endmodule

`default_nettype wire

// ===== testbench/tb_top.sv
/*
  Self-checking bench for the data-space decoder.
  Assumes the hand-over timing: internal answers one cycle, external two.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import dmd_pkg::*;
  logic clock, sys_rst, req_valid, req_write, req_wbit, dma_valid, dma_write;
  dmd_mode_t req_mode;
  logic [7:0] req_addr, req_wdata, dma_addr, dma_wdata, ext_rdata, rsp_data, port0_out, port2_out, ext_wdata, rd;
  logic [15:0] req_wide_ptr;
  logic req_ready, dma_ready, rsp_valid, rsp_bit, port0_oe, port2_addr_mode, ext_rd, ext_wr, rb;
  int error_cnt, n_tests;

  dmd_data_space dmd_data_space_inst (.clock, .sys_rst, .req_valid, .req_ready, .req_mode, .req_write,
    .req_addr, .req_wide_ptr, .req_wdata, .req_wbit, .dma_valid, .dma_ready, .dma_write, .dma_addr,
    .dma_wdata, .rsp_valid, .rsp_data, .rsp_bit, .port0_out, .port0_oe, .port2_out,
    .port2_addr_mode, .ext_rd, .ext_wr, .ext_wdata, .ext_rdata);
  dmd_ext_mem dmd_ext_mem_inst (.clock, .port0_out, .port2_out, .ext_rd, .ext_wr, .ext_wdata, .ext_rdata);

  // Clock at 100 MHz
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic complete_run();
    $display("compares %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up();
    error_cnt++;
    $display("wait limit reached at %0t", $time);
    complete_run();
  endtask

  // Core request held until taken; reads return mid-cycle after the answer, writes after the take
  task automatic do_req(input dmd_mode_t m, input logic w, input logic [7:0] a, input logic [15:0] dp,
                        input logic [7:0] wd, input logic wb);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_mode <= m;
    req_write <= w;
    req_addr <= a;
    req_wide_ptr <= dp;
    req_wdata <= wd;
    req_wbit <= wb;
    @(negedge clock);
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 8) give_up();
      @(negedge clock);
    end
    @(posedge clock);
    req_valid <= 1'b0;
    @(negedge clock);
    n = 0;
    while (!w && rsp_valid !== 1'b1) begin
      n++;
      if (n > 4) give_up();
      @(negedge clock);
    end
    rd = rsp_data;
    rb = rsp_bit;
  endtask

  // DMA request, only granted while the core is quiet
  task automatic do_dma(input logic w, input logic [7:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    dma_valid <= 1'b1;
    dma_write <= w;
    dma_addr <= a;
    dma_wdata <= wd;
    @(negedge clock);
    while (dma_ready !== 1'b1) begin
      n++;
      if (n > 8) give_up();
      @(negedge clock);
    end
    @(posedge clock);
    dma_valid <= 1'b0;
    @(negedge clock);
    rd = rsp_data;
    if (!w) check1(rsp_valid, 1'b1);
  endtask

  task automatic test_ram();
    do_req(MODE_DIRECT, 1'b1, 8'h30, 16'h0000, 8'h5a, 1'b0);
    do_req(MODE_INDIRECT, 1'b0, 8'h30, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'h5a);
    do_req(MODE_INDIRECT, 1'b1, 8'h7f, 16'h0000, 8'hc4, 1'b0);
    do_req(MODE_DIRECT, 1'b0, 8'h7f, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'hc4);
    do_req(MODE_INDIRECT, 1'b1, 8'hff, 16'h0000, 8'h6e, 1'b0);
    do_req(MODE_INDIRECT, 1'b1, 8'h90, 16'h0000, 8'ha5, 1'b0);
    do_req(MODE_DIRECT, 1'b1, 8'h90, 16'h0000, 8'h3c, 1'b0);
    do_req(MODE_INDIRECT, 1'b0, 8'h90, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'ha5);
    do_req(MODE_DIRECT, 1'b0, 8'h90, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'h3c);
    do_req(MODE_INDIRECT, 1'b0, 8'hff, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'h6e);
    do_req(MODE_STACK, 1'b1, 8'h91, 16'h0000, 8'h77, 1'b0);
    do_req(MODE_DIRECT, 1'b1, 8'h91, 16'h0000, 8'h11, 1'b0);
    do_req(MODE_INDIRECT, 1'b0, 8'h91, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'h77);
    do_dma(1'b1, 8'hc0, 8'he1);
    do_dma(1'b0, 8'hc0, 8'h00);
    check8(rd, 8'he1);
    do_req(MODE_INDIRECT, 1'b0, 8'hc0, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'he1);
    do_req(MODE_DIRECT, 1'b0, 8'hc0, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'h00);
    do_dma(1'b0, 8'hc0, 8'h00);
    check8(rd, 8'he1);
    $display("test ram done");
  endtask

  task automatic test_bits();
    logic [7:0] bl [4] = '{8'h00, 8'h07, 8'h08, 8'h7f};
    foreach (bl[i]) do_req(MODE_BIT, 1'b1, bl[i], 16'h0000, 8'h00, 1'b1);
    do_req(MODE_INDIRECT, 1'b0, 8'h20, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'h81);
    do_req(MODE_INDIRECT, 1'b0, 8'h21, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'h01);
    do_req(MODE_INDIRECT, 1'b0, 8'h2f, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'h80);
    do_req(MODE_BIT, 1'b0, 8'h06, 16'h0000, 8'h00, 1'b0);
    check1(rb, 1'b0);
    do_req(MODE_BIT, 1'b1, 8'h8b, 16'h0000, 8'h00, 1'b1);
    do_req(MODE_DIRECT, 1'b0, 8'h88, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'h08);
    do_req(MODE_BIT, 1'b1, 8'hfd, 16'h0000, 8'h00, 1'b1);
    do_req(MODE_DIRECT, 1'b0, 8'hf8, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'h20);
    do_req(MODE_BIT, 1'b1, 8'haf, 16'h0000, 8'h00, 1'b1);
    do_req(MODE_BIT, 1'b1, 8'hae, 16'h0000, 8'h00, 1'b1);
    do_req(MODE_DIRECT, 1'b0, 8'ha8, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'h80);
    do_req(MODE_BIT, 1'b0, 8'haf, 16'h0000, 8'h00, 1'b0);
    check1(rb, 1'b1);
    $display("test bits done");
  endtask

  task automatic test_ext();
    do_req(MODE_EXT_WIDE, 1'b1, 8'h00, 16'h1234, 8'hc3, 1'b0);
    check8(port0_out, 8'h34);
    check1(port0_oe, 1'b1);
    check8(port2_out, 8'h12);
    check1(port2_addr_mode, 1'b1);
    check1(ext_wr, 1'b1);
    check8(ext_wdata, 8'hc3);
    do_req(MODE_EXT_WIDE, 1'b1, 8'h00, 16'hffff, 8'h9e, 1'b0);
    do_req(MODE_EXT_WIDE, 1'b0, 8'h00, 16'h1234, 8'h00, 1'b0);
    check8(rd, 8'hc3);
    do_req(MODE_EXT_WIDE, 1'b0, 8'h00, 16'hffff, 8'h00, 1'b0);
    check8(rd, 8'h9e);
    check8(port2_out, 8'hff);
    do_req(MODE_DIRECT, 1'b1, 8'ha0, 16'h0000, 8'h5b, 1'b0);
    do_req(MODE_EXT_REG, 1'b1, 8'h77, 16'haaaa, 8'h4d, 1'b0);
    check8(port0_out, 8'h77);
    check8(port2_out, 8'h5b);
    check1(port2_addr_mode, 1'b0);
    do_req(MODE_EXT_REG, 1'b0, 8'h77, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'h4d);
    do_req(MODE_DIRECT, 1'b1, 8'ha0, 16'h0000, 8'h5c, 1'b0);
    do_req(MODE_EXT_REG, 1'b0, 8'h77, 16'h0000, 8'h00, 1'b0);
    check8(rd, 8'h00);
    $display("test ext done");
  endtask

  // Main sequence: reset for two cycles, then the scenarios
  initial begin
    error_cnt = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    {req_valid, req_write, req_wbit, dma_valid, dma_write} = 5'h00;
    req_mode = MODE_DIRECT;
    {req_addr, req_wdata, dma_addr, dma_wdata} = 32'h0000_0000;
    req_wide_ptr = 16'h0000;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    check8(port2_out, 8'hff);
    test_ram();
    test_bits();
    test_ext();
    complete_run();
  end
endmodule

`default_nettype wire
